// [fapd_map.svh]
`ifndef FAPD_MAP_SVH
`define FAPD_MAP_SVH

// ----------------------------------------
// Output register I/O address and register offsets (low I/O address bits)
// ----------------------------------------
`define FAPD_OCTL_ADDR       10'h03F2
`define FAPD_DSR_OFS         3'h4
`define FAPD_STAT_OFS        3'h4
`define FAPD_DATA_OFS        3'h5
`define FAPD_OCTL_OFS        3'h2

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define FAPD_CFG_EN_BIT      0
`define FAPD_OCTL_RST_N_BIT  2
`define FAPD_OCTL_MOT_LSB    4
`define FAPD_DSR_RST_BIT     7
`define FAPD_DSR_PD_BIT      6
`define FAPD_STAT_IDLE       8'h80
`define FAPD_OCTL_RESET      8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define FAPD_CLK_HZ          40000000
`define FAPD_TIMER_MS        10
`define FAPD_TIMER_CYC       ((`FAPD_CLK_HZ / 1000) * `FAPD_TIMER_MS)

`endif

// [fapd_pkg.sv]
package fapd_pkg;

    typedef enum logic [1:0] {
        FAPD_AWAKE,
        FAPD_AUTO_PD,
        FAPD_DIRECT_PD
    } fapd_state_t;

    // One host I/O access to the controller window
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] ofs;
        logic [7:0] wdata;
    } fapd_acc_t;

    // Drive-side outputs gated by powerdown
    typedef struct packed {
        logic [3:0] motor_en;
        logic [3:0] drive_sel;
        logic       wr_data;
        logic       wr_gate;
    } fapd_drv_t;

endpackage

// [fapd_timer.sv]
`timescale 1ns/1ps
`include "fapd_map.svh"

// Idle timer: counts down from load value, flags done when it reaches zero
module fapd_timer
    import fapd_pkg::*;
#(
    parameter int CYCLES = `FAPD_TIMER_CYC
)(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic restart,
    input  wire logic run,
    // Status
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);

    logic [W-1:0] cnt_r;

    always_ff @(posedge clk)
    begin
        if (rst || restart || !run)
        begin
            cnt_r <= W'(CYCLES);
            done  <= 1'b0;
        end
        else if (cnt_r != '0)
        begin
            cnt_r <= cnt_r - W'(1);
            done  <= (cnt_r == W'(1));
        end
    end
endmodule

// [fapd_ctrl.sv]
`timescale 1ns/1ps
`include "fapd_map.svh"

// Notes on behaviour
// - Auto powerdown may only happen while bit 0 of the auto power config register is set.
// - Entry needs all four motor enable bits of the drive output control register at zero.
// - Entry needs the main status register at 80H and the controller interrupt low.
// - Entry needs the head unload timer to have run out.
// - Entry needs the 10 ms auto powerdown timer to have completed.
// - The timer starts when auto powerdown is enabled and entry happens once all conditions hold.
// - Clearing the enable cancels the timer and keeps the controller out of auto powerdown.
// - Rate-select powerdown overrides auto powerdown, and auto powerdown applies again after it.
// - Waking by reset pin or a software reset bit runs the normal reset sequence.
// - Waking by a register access keeps controller state untouched.
// - Writing a motor enable bit active wakes the part; reading the output register does not.
// - A read of the main status register wakes the part.
// - Any read or write of the data register wakes the part.
// - After every wake the 10 ms timer restarts and entry happens again when conditions hold.
// - Other register accesses do not wake the part and written values are kept.
// - In powerdown motor enables, drive selects, write data and write gate are tristated.
module fapd_ctrl
    import fapd_pkg::*;
#(
    parameter int TIMER_CYC = `FAPD_TIMER_CYC
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Host access decoded to the controller window (same clock domain)
    input  wire fapd_acc_t   acc,
    // Configuration
    input  wire logic [7:0]  auto_power_config_reg,
    // Controller core status
    input  wire logic [7:0]  main_status_reg,
    input  wire logic        ctrl_int,
    input  wire logic        head_unload_done,
    input  wire fapd_drv_t   core_drv,
    // Register and power state
    output logic [7:0]       drive_output_control,
    output logic             powered_down,
    output logic             direct_pd,
    output logic             ctrl_reset,
    output logic             wake_pulse,
    // Drive pins
    output fapd_drv_t        drv_out,
    output fapd_drv_t        drv_oe
);
    // ----------------------------------------
    // Access decode
    // ----------------------------------------
    logic auto_en;
    logic octl_wr;
    logic dsr_wr;
    logic sw_reset;
    logic acc_wake;
    logic wake;
    logic conds_ok;
    logic tmr_done;
    logic tmr_restart;
    fapd_state_t state_r;
    fapd_state_t state_nxt;

    assign auto_en  = auto_power_config_reg[`FAPD_CFG_EN_BIT];
    assign octl_wr  = acc.wr && (acc.ofs == `FAPD_OCTL_OFS);
    assign dsr_wr   = acc.wr && (acc.ofs == `FAPD_DSR_OFS);
    // Software reset: output register reset bit low, or rate register reset bit high
    assign sw_reset = (octl_wr && !acc.wdata[`FAPD_OCTL_RST_N_BIT])
                    || (dsr_wr && acc.wdata[`FAPD_DSR_RST_BIT]);
    // Plain output register reads and other registers do not wake
    assign acc_wake = (octl_wr && (acc.wdata[7:4] != 4'h0))
                    || (acc.rd && acc.ofs == `FAPD_STAT_OFS)
                    || ((acc.rd || acc.wr) && acc.ofs == `FAPD_DATA_OFS);
    assign wake     = acc_wake || sw_reset;

    assign conds_ok = auto_en
                    && (drive_output_control[7:4] == 4'h0)
                    && (main_status_reg == `FAPD_STAT_IDLE) && !ctrl_int
                    && head_unload_done
                    && tmr_done;

    // Timer restarts on every wake, cleared while disabled
    assign tmr_restart = wake || (state_r != FAPD_AWAKE);

    fapd_timer #(
        .CYCLES (TIMER_CYC)
    ) u_timer (
        .clk     (clk),
        .rst     (rst),
        .restart (tmr_restart),
        .run     (auto_en),
        .done    (tmr_done)
    );

    // ----------------------------------------
    // Power state
    // ----------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            FAPD_AWAKE:
            begin
                if (dsr_wr && acc.wdata[`FAPD_DSR_PD_BIT] && !sw_reset)
                    state_nxt = FAPD_DIRECT_PD;
                else if (conds_ok && !wake)
                    state_nxt = FAPD_AUTO_PD;
            end
            FAPD_AUTO_PD:
            begin
                if (dsr_wr && acc.wdata[`FAPD_DSR_PD_BIT] && !sw_reset)
                    state_nxt = FAPD_DIRECT_PD;
                else if (wake || !auto_en)
                    state_nxt = FAPD_AWAKE;
            end
            FAPD_DIRECT_PD:
            begin
                // Direct powerdown ends on a reset; auto control resumes afterwards
                if (sw_reset)
                    state_nxt = FAPD_AWAKE;
            end
            default:
                state_nxt = FAPD_AWAKE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            state_r <= FAPD_AWAKE;
        else
            state_r <= state_nxt;
    end

    // ----------------------------------------
    // Drive output control register
    // ----------------------------------------
    // Written values are held in powerdown too
    always_ff @(posedge clk)
    begin
        if (rst)
            drive_output_control <= `FAPD_OCTL_RESET;
        else if (octl_wr)
            drive_output_control <= acc.wdata;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            powered_down <= 1'b0;
            direct_pd    <= 1'b0;
            ctrl_reset   <= 1'b1;
            wake_pulse   <= 1'b0;
        end
        else
        begin
            powered_down <= (state_nxt != FAPD_AWAKE);
            direct_pd    <= (state_nxt == FAPD_DIRECT_PD);
            // Only resets restart the core; access wakes leave it alone
            ctrl_reset   <= sw_reset;
            wake_pulse   <= (state_r != FAPD_AWAKE) && (state_nxt == FAPD_AWAKE);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            drv_out <= '0;
            drv_oe  <= '0;
        end
        else
        begin
            drv_out <= core_drv;
            drv_oe  <= (state_nxt == FAPD_AWAKE) ? '1 : '0;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    auto_needs_en_a: assert property (@(posedge clk) disable iff (rst)
        $rose(powered_down) && !direct_pd |-> $past(auto_en))
        else $error("auto powerdown while disabled");
    motors_off_a: assert property (@(posedge clk) disable iff (rst)
        $rose(powered_down) && !direct_pd |-> $past(drive_output_control[7:4]) == 4'h0)
        else $error("powerdown with motor enabled");
    idle_needed_a: assert property (@(posedge clk) disable iff (rst)
        $rose(powered_down) && !direct_pd |-> $past(main_status_reg) == 8'h80 && !$past(ctrl_int))
        else $error("powerdown while busy");
    head_unload_a: assert property (@(posedge clk) disable iff (rst)
        $rose(powered_down) && !direct_pd |-> $past(head_unload_done))
        else $error("powerdown before head unload");
    timer_done_a: assert property (@(posedge clk) disable iff (rst)
        $rose(powered_down) && !direct_pd |-> $past(tmr_done))
        else $error("powerdown before timer");
    disable_exit_a: assert property (@(posedge clk) disable iff (rst)
        !auto_en && state_r == FAPD_AUTO_PD |=> !powered_down)
        else $error("disable did not wake");
    status_wake_a: assert property (@(posedge clk) disable iff (rst)
        state_r == FAPD_AUTO_PD && acc.rd && acc.ofs == 3'h4 |=> !powered_down ##1 !tmr_done)
        else $error("status read did not wake");
    data_wake_a: assert property (@(posedge clk) disable iff (rst)
        state_r == FAPD_AUTO_PD && (acc.rd || acc.wr) && acc.ofs == 3'h5 |=> wake_pulse)
        else $error("data access did not wake");
    ctl_read_a: assert property (@(posedge clk) disable iff (rst)
        state_r == FAPD_AUTO_PD && acc.rd && acc.ofs == 3'h2 && !acc.wr |=> powered_down)
        else $error("output register read woke part");
    tristate_pd_a: assert property (@(posedge clk) disable iff (rst)
        powered_down |-> drv_oe == '0)
        else $error("drive pins driven in powerdown");
    wake_wins_a: assert property (@(posedge clk) disable iff (rst)
        state_r == FAPD_AWAKE && wake |=> !powered_down || direct_pd)
        else $error("entry beat wake");

    enter_auto_c: cover property (@(posedge clk) disable iff (rst)
        state_r == FAPD_AWAKE ##1 state_r == FAPD_AUTO_PD);
    wake_access_c: cover property (@(posedge clk) disable iff (rst)
        state_r == FAPD_AUTO_PD && acc_wake);
    direct_pd_c: cover property (@(posedge clk) disable iff (rst)
        state_r == FAPD_AUTO_PD ##1 state_r == FAPD_DIRECT_PD);
endmodule

// [fapd_host.sv]
`timescale 1ns/1ps

module fapd_host
    import fapd_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Host access and wake report
    output fapd_acc_t acc,
    input  wire logic wake_pulse
);
    initial acc = '0;

    // One-cycle strobe; the wake pulse is read after the sampling edge has landed
    task automatic io(input logic rd, input logic wr, input logic [2:0] ofs, input logic [7:0] wd,
                      output logic woke);
        @(posedge clk);
        acc <= '{rd: rd, wr: wr, ofs: ofs, wdata: wd};
        @(posedge clk);
        acc <= '0;
        #1;
        woke = wake_pulse;
    endtask
endmodule

// [fdc_auto_powerdown_control_bench.sv]
`timescale 1ns/1ps

`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %0h seen %0h", w, e, g); end end

module fdc_auto_powerdown_control_bench
    import fapd_pkg::*;
;
    localparam int TCYC = 20;
    logic      clk = 0;
    logic      rst = 1;
    logic      ctrl_int = 0;
    logic      hud = 1;
    logic      woke;
    logic [7:0] cfg = 8'h00;
    logic [7:0] stat = 8'h80;
    logic [7:0] octl;
    logic      pd, dpd, crst, wake;
    fapd_acc_t acc;
    fapd_drv_t drv_out, drv_oe;
    int        n_errors = 0;
    int        comparisons = 0;

    always #12.5 clk = ~clk;

    fapd_host host_u (.clk(clk), .acc(acc), .wake_pulse(wake));

    fapd_ctrl #(.TIMER_CYC(TCYC)) dut_u (
        .clk(clk), .rst(rst), .acc(acc), .auto_power_config_reg(cfg), .main_status_reg(stat),
        .ctrl_int(ctrl_int), .head_unload_done(hud), .core_drv(10'h2A5),
        .drive_output_control(octl), .powered_down(pd), .direct_pd(dpd), .ctrl_reset(crst),
        .wake_pulse(wake), .drv_out(drv_out), .drv_oe(drv_oe)
    );

    task automatic settle(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wait_pd(logic want);
        for (int i = 0; i < 40 && pd !== want; i++) settle(1);
        `CHK("powered_down", want, pd)
    endtask

    task automatic t_entry();
        @(posedge clk) cfg <= 8'h01;
        settle(TCYC - 4);
        `CHK("early", 1'b0, pd)
        wait_pd(1'b1);
        `CHK("drv_oe", 10'h000, drv_oe)
        `CHK("drv_out", 10'h2A5, drv_out)
    endtask

    // ----------------------------------------
    // Wake and non-wake accesses
    // ----------------------------------------
    task automatic t_wake();
        logic [12:0] tab [4] = '{{2'b10, 3'h4, 8'h00}, {2'b10, 3'h5, 8'h00},
                                 {2'b01, 3'h5, 8'h00}, {2'b01, 3'h2, 8'h14}};
        foreach (tab[k])
        begin
            wait_pd(1'b1);
            host_u.io(tab[k][12], tab[k][11], tab[k][10:8], tab[k][7:0], woke);
            `CHK("wake", 1'b1, woke)
            `CHK("awake", 1'b0, pd)
            `CHK("drv_oe on", 10'h3FF, drv_oe)
            if (k == 3) host_u.io(1'b0, 1'b1, 3'h2, 8'h04, woke);
            settle(TCYC - 6);
            `CHK("restart", 1'b0, pd)
        end
    endtask

    task automatic t_nowake();
        logic [12:0] tab [4] = '{{2'b10, 3'h2, 8'h00}, {2'b01, 3'h4, 8'h02},
                                 {2'b10, 3'h0, 8'h00}, {2'b01, 3'h2, 8'h0C}};
        wait_pd(1'b1);
        foreach (tab[k])
        begin
            host_u.io(tab[k][12], tab[k][11], tab[k][10:8], tab[k][7:0], woke);
            `CHK("no wake", 1'b0, woke)
            `CHK("still down", 1'b1, pd)
        end
        `CHK("octl kept", 8'h0C, octl)
    endtask

    // Each case holds one entry condition false; auto powerdown must not happen
    task automatic t_block();
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clk) cfg <= 8'h00;
            settle(2);
            `CHK("disable", 1'b0, pd)
            @(posedge clk);
            stat <= (k == 1) ? 8'h10 : 8'h80;
            ctrl_int <= (k == 2);
            hud <= (k != 3);
            cfg <= (k == 0) ? 8'h00 : 8'h01;
            if (k == 4) host_u.io(1'b0, 1'b1, 3'h2, 8'h14, woke);
            settle(3 * TCYC);
            `CHK("blocked", 1'b0, pd)
            @(posedge clk);
            stat <= 8'h80;
            ctrl_int <= 1'b0;
            hud <= 1'b1;
            cfg <= 8'h01;
            if (k == 4) host_u.io(1'b0, 1'b1, 3'h2, 8'h04, woke);
            wait_pd(1'b1);
        end
    endtask

    task automatic t_direct();
        host_u.io(1'b0, 1'b1, 3'h4, 8'h40, woke);
        settle(1);
        `CHK("direct pd", 1'b1, dpd)
        host_u.io(1'b0, 1'b1, 3'h4, 8'h80, woke);
        `CHK("sw reset", 1'b1, crst)
        settle(2);
        `CHK("direct exit", 1'b0, dpd)
        wait_pd(1'b1);
        host_u.io(1'b0, 1'b1, 3'h2, 8'h00, woke);
        `CHK("octl reset wake", 1'b1, woke)
        `CHK("octl sw reset", 1'b1, crst)
        @(posedge clk) rst <= 1'b1;
        settle(3);
        @(posedge clk) rst <= 1'b0;
        settle(1);
        `CHK("hw reset pd", 1'b0, pd)
        `CHK("hw reset octl", 8'h00, octl)
    endtask

    task automatic test_done();
        $display("Errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        #500000;
        n_errors++;
        test_done();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        `CHK("reset octl", 8'h00, octl)
        t_entry();
        t_wake();
        t_nowake();
        t_block();
        t_direct();
        test_done();
    end
endmodule
